// ==== verilog/kbe_defines.svh ====
// register offsets, field positions, command codes and reset values
`ifndef KBE_DEFINES_SVH
`define KBE_DEFINES_SVH

`define KBE_PORT_INDEX   16'h0022
`define KBE_PORT_DATA    16'h0023
`define KBE_PORT_OBUF    16'h0060
`define KBE_PORT_STAT    16'h0064

`define KBE_IDX_CFGA     8'hC0
`define KBE_IDX_CFGB     8'hC1
`define KBE_IDX_IBUF     8'hC2
`define KBE_IDX_KOBUF    8'hC3
`define KBE_IDX_MOBUF    8'hC4
`define KBE_IDX_STATW    8'hC5

`define KBE_CFGA_MSEL    0
`define KBE_CFGA_A20DIS  1
`define KBE_CFGA_RSTDIS  2
`define KBE_CFGA_IRQ1EN  4
`define KBE_CFGA_IRQ12EN 5

`define KBE_CFGB_CLKREL  0
`define KBE_CFGB_ACK     1
`define KBE_CFGB_RT_LO   2
`define KBE_CFGB_RT_HI   3
`define KBE_CFGB_XTEN    4
`define KBE_CFGB_XTSEL   5
`define KBE_CFGB_TMR     6

`define KBE_STAT_OBF     0
`define KBE_STAT_IBF     1
`define KBE_STAT_CMD     3
`define KBE_STAT_AUX     5

`define KBE_CMD_A20      8'hD1
`define KBE_CMD_RST      8'hFE
`define KBE_A20_DATA_BIT 1

`define KBE_CFG_RESET    8'h00
`define KBE_STAT_RESET   8'h00
`define KBE_BUF_RESET    8'h00
`define KBE_UNMAPPED     8'hFF
`define KBE_XT_LAST_BIT  4'h8

`endif

// ==== verilog/kbe_pkg.sv ====
// types shared by the keyboard controller emulation
package kbe_pkg;

  typedef enum logic [1:0] {
    KBE_ROUTE_NONE  = 2'b00,
    KBE_ROUTE_INT   = 2'b01,
    KBE_ROUTE_EXT   = 2'b10,
    KBE_ROUTE_NONE2 = 2'b11
  } kbe_route_e;

  typedef enum logic {
    KBE_SNOOP_IDLE = 1'b0,
    KBE_SNOOP_DATA = 1'b1
  } kbe_snoop_e;

endpackage

// ==== verilog/kbe_sync3.sv ====
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module kbe_sync3 (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic resetn_in,
  // asynchronous level in, filtered level out
  input  wire logic async_in,
  output logic      level_out
);

  logic q1;
  logic q2;
  logic q3;

  // idle level of the open-drain lines is high
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      q1 <= 1'b1;
      q2 <= 1'b1;
      q3 <= 1'b1;
    end else begin
      q1 <= async_in;
      q2 <= q1;
      q3 <= q2;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      level_out <= 1'b1;
    end else if (q2 == q3) begin
      level_out <= q3;
    end
  end

endmodule

// ==== verilog/kbe_xt_rx.sv ====
// serial keyboard receiver: start bit plus eight data bits, lsb first
`timescale 1ns/10ps
module kbe_xt_rx
  import kbe_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  // control
  input  wire logic       run_in,
  // synchronised line levels
  input  wire logic       clk_lvl_in,
  input  wire logic       data_lvl_in,
  // received byte
  output logic [7:0]      byte_out,
  output logic            valid_out
);
`include "kbe_defines.svh"

  logic       clk_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       fall;

  assign fall = clk_prev & ~clk_lvl_in;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= clk_lvl_in;
    end
  end

  // held idle while not running, so a stalled frame cannot leave stale bits
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bit_cnt   <= 4'h0;
      shift     <= `KBE_BUF_RESET;
      byte_out  <= `KBE_BUF_RESET;
      valid_out <= 1'b0;
    end else if (!run_in) begin
      bit_cnt   <= 4'h0;
      shift     <= `KBE_BUF_RESET;
      valid_out <= 1'b0;
    end else if (fall) begin
      if (bit_cnt == `KBE_XT_LAST_BIT) begin
        byte_out  <= {data_lvl_in, shift[7:1]};
        valid_out <= 1'b1;
        bit_cnt   <= 4'h0;
        shift     <= `KBE_BUF_RESET;
      end else begin
        if (bit_cnt != 4'h0) begin
          shift <= {data_lvl_in, shift[7:1]};
        end
        bit_cnt   <= bit_cnt + 4'h1;
        valid_out <= 1'b0;
      end
    end else begin
      valid_out <= 1'b0;
    end
  end

endmodule

// ==== verilog/kbe_top.sv ====
// keyboard controller emulation: routing, gate snoop, status, irqs, xt input
//
// Summary of operation
// - after reset the address line 20 gate propagates until a command clears it
// - snoop disable bit stops the gate state machine and its forcing
// - status_bit5_meaning_select picks time-out or mouse-full for status bit 5
// - in mouse mode a mouse buffer write sets bit 5, keyboard write clears it
// - no mouse irq while status_bit5_meaning_select is clear
// - irq1 enable only matters for internal route or none with xt irq mode
// - internal route with enable raises irq1 on keyboard buffer writes
// - shared irq1 is the or of both sources, one edge only
// - timer trap status sets on time-out, write 0 clears, write 1 ignored
// - xt byte goes to irq1 or to smi/nmi per route select
// - xt trap route suppresses matrix key smi/nmi
// - with xt enabled each received byte lands in the output buffer unless a buffer register write comes in the same cycle
// - port 60h returns xt data only on internal route, external goes out
// - route field picks internal, external bus or neither for 60h/64h
// - route field does not affect gate or hot reset snooping
// - writes to 60h/64h land in the internal emulation buffer
// - external route disables internal irq1 and irq12
// - acknowledge bit holds data low and clears the receive shifter
// - clock release bit clear holds the xt clock low
// - output buffer holds whichever of xt byte or buffer writes came last
`timescale 1ns/10ps
module kbe_top
  import kbe_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  // cpu i/o cycle
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [7:0]  io_wdata_in,
  output logic [7:0]       io_rdata_out,
  output logic             ext_kbc_select_out,
  // system side
  output logic             a20_gate_out,
  output logic             hot_reset_out,
  output logic             irq1_out,
  output logic             irq12_out,
  output logic             smi_out,
  output logic             nmi_out,
  output logic             xt_trap_status_out,
  output logic             matrix_key_trap_out,
  // trap control from the power management side
  input  wire logic        kbd_trap_enable_in,
  input  wire logic        trap_nmi_select_in,
  input  wire logic        xt_trap_clear_in,
  input  wire logic        matrix_key_event_in,
  input  wire logic        kbd_timer_timeout_in,
  // xt keyboard lines, open drain
  input  wire logic        xt_clk_in,
  output logic             xt_clk_out,
  output logic             xt_clk_oe_out,
  input  wire logic        xt_data_in,
  output logic             xt_data_out,
  output logic             xt_data_oe_out
);
`include "kbe_defines.svh"

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] index;
  logic [7:0] cfga;
  logic [7:0] cfgb;
  logic [7:0] ibuf;
  logic [7:0] obuf;
  logic [7:0] status;
  logic       a20_level;
  logic       kbd_src;
  logic       xt_src;
  logic       mouse_src;
  logic       xt_trap;
  kbe_snoop_e snoop;
  kbe_route_e route;
  logic       xt_clk_lvl;
  logic       xt_data_lvl;
  logic [7:0] xt_byte;
  logic       xt_valid;
  logic       xt_run;
  logic [7:0] next_rdata;

  logic wr_dat, rd_dat, wr60, wr64, rd60, rd64;
  logic wr_c0, wr_c1, wr_c3, wr_c4, wr_c5, rd_c2;
  logic xt_en, xt_sel, xt_in;

  assign route  = kbe_route_e'(cfgb[`KBE_CFGB_RT_HI:`KBE_CFGB_RT_LO]);
  assign xt_en  = cfgb[`KBE_CFGB_XTEN];
  assign xt_sel = cfgb[`KBE_CFGB_XTSEL];
  assign xt_in  = xt_valid & xt_en;

  assign wr_dat = io_wr_in & (io_addr_in == `KBE_PORT_DATA);
  assign rd_dat = io_rd_in & (io_addr_in == `KBE_PORT_DATA);
  assign wr60   = io_wr_in & (io_addr_in == `KBE_PORT_OBUF);
  assign wr64   = io_wr_in & (io_addr_in == `KBE_PORT_STAT);
  assign rd60   = io_rd_in & (io_addr_in == `KBE_PORT_OBUF);
  assign rd64   = io_rd_in & (io_addr_in == `KBE_PORT_STAT);
  assign wr_c0  = wr_dat & (index == `KBE_IDX_CFGA);
  assign wr_c1  = wr_dat & (index == `KBE_IDX_CFGB);
  assign wr_c3  = wr_dat & (index == `KBE_IDX_KOBUF);
  assign wr_c4  = wr_dat & (index == `KBE_IDX_MOBUF);
  assign wr_c5  = wr_dat & (index == `KBE_IDX_STATW);
  assign rd_c2  = rd_dat & (index == `KBE_IDX_IBUF);

  ////////////////////////////////////////////////////////////////////////////
  // xt receiver
  kbe_sync3 u_sync_clk (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (xt_clk_in),
    .level_out (xt_clk_lvl)
  );

  kbe_sync3 u_sync_data (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (xt_data_in),
    .level_out (xt_data_lvl)
  );

  // ack high or clock held also clears the shifter
  assign xt_run = xt_en & cfgb[`KBE_CFGB_CLKREL] & ~cfgb[`KBE_CFGB_ACK];

  kbe_xt_rx u_rx (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .run_in      (xt_run),
    .clk_lvl_in  (xt_clk_lvl),
    .data_lvl_in (xt_data_lvl),
    .byte_out    (xt_byte),
    .valid_out   (xt_valid)
  );

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      xt_clk_out     <= 1'b0;
      xt_data_out    <= 1'b0;
      xt_clk_oe_out  <= 1'b0;
      xt_data_oe_out <= 1'b0;
    end else begin
      xt_clk_out     <= 1'b0;
      xt_data_out    <= 1'b0;
      xt_clk_oe_out  <= xt_en & ~cfgb[`KBE_CFGB_CLKREL];
      xt_data_oe_out <= xt_en & cfgb[`KBE_CFGB_ACK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // index and configuration registers
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      index <= `KBE_CFG_RESET;
    end else if (io_wr_in && io_addr_in == `KBE_PORT_INDEX) begin
      index <= io_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cfga <= `KBE_CFG_RESET;
    end else if (wr_c0) begin
      cfga <= io_wdata_in;
    end
  end

  // timer trap status: hardware set wins over a software clear
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cfgb <= `KBE_CFG_RESET;
    end else begin
      if (wr_c1) begin
        cfgb[5:0] <= io_wdata_in[5:0];
      end
      if (kbd_timer_timeout_in) begin
        cfgb[`KBE_CFGB_TMR] <= 1'b1;
      end else if (wr_c1 && !io_wdata_in[`KBE_CFGB_TMR]) begin
        cfgb[`KBE_CFGB_TMR] <= 1'b0;
      end
      cfgb[7] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // emulated buffers and status
  // cpu writes are captured on every route so emulation code can inspect them
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ibuf <= `KBE_BUF_RESET;
    end else if (wr60 || wr64) begin
      ibuf <= io_wdata_in;
    end
  end

  // register writes win a same-cycle tie with an xt byte
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      obuf <= `KBE_BUF_RESET;
    end else if (wr_c3 || wr_c4) begin
      obuf <= io_wdata_in;
    end else if (xt_in) begin
      obuf <= xt_byte;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      status <= `KBE_STAT_RESET;
    end else begin
      if (wr_c5) begin
        status <= io_wdata_in;
      end
      if (wr_c3 || wr_c4 || xt_in) begin
        status[`KBE_STAT_OBF] <= 1'b1;
      end else if (rd60 && route == KBE_ROUTE_INT) begin
        status[`KBE_STAT_OBF] <= 1'b0;
      end
      if (wr60 || wr64) begin
        status[`KBE_STAT_IBF] <= 1'b1;
        status[`KBE_STAT_CMD] <= wr64;
      end else if (rd_c2) begin
        status[`KBE_STAT_IBF] <= 1'b0;
      end
      if (cfga[`KBE_CFGA_MSEL]) begin
        if (wr_c4) begin
          status[`KBE_STAT_AUX] <= 1'b1;
        end else if (wr_c3) begin
          status[`KBE_STAT_AUX] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate and hot reset snooping, independent of the route field
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      snoop     <= KBE_SNOOP_IDLE;
      a20_level <= 1'b1;
    end else if (cfga[`KBE_CFGA_A20DIS]) begin
      snoop <= KBE_SNOOP_IDLE;
    end else begin
      case (snoop)
        KBE_SNOOP_IDLE: begin
          if (wr64 && io_wdata_in == `KBE_CMD_A20) begin
            snoop <= KBE_SNOOP_DATA;
          end
        end
        KBE_SNOOP_DATA: begin
          if (wr60) begin
            a20_level <= io_wdata_in[`KBE_A20_DATA_BIT];
            snoop     <= KBE_SNOOP_IDLE;
          end else if (wr64) begin
            snoop <= KBE_SNOOP_IDLE;
          end
        end
        default: begin
          snoop <= KBE_SNOOP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      a20_gate_out  <= 1'b1;
      hot_reset_out <= 1'b0;
    end else begin
      a20_gate_out  <= a20_level & ~cfga[`KBE_CFGA_A20DIS];
      hot_reset_out <= wr64 & (io_wdata_in == `KBE_CMD_RST)
                       & ~cfga[`KBE_CFGA_RSTDIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources: set wins over the clearing read
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      kbd_src   <= 1'b0;
      mouse_src <= 1'b0;
      xt_src    <= 1'b0;
    end else begin
      if (wr_c3 && route == KBE_ROUTE_INT) begin
        kbd_src <= 1'b1;
      end else if (rd60) begin
        kbd_src <= 1'b0;
      end
      if (wr_c4 && route == KBE_ROUTE_INT) begin
        mouse_src <= 1'b1;
      end else if (rd60) begin
        mouse_src <= 1'b0;
      end
      if (xt_in && !xt_sel && route != KBE_ROUTE_EXT) begin
        xt_src <= 1'b1;
      end else if (rd60 || !xt_en) begin
        xt_src <= 1'b0;
      end
    end
  end

  // one or-ed level: a second source during the first makes no new edge,
  // so handlers must drain both or toggle the enable
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      irq1_out  <= 1'b0;
      irq12_out <= 1'b0;
    end else begin
      irq1_out  <= cfga[`KBE_CFGA_IRQ1EN] & (route != KBE_ROUTE_EXT)
                   & (kbd_src | xt_src);
      irq12_out <= mouse_src & cfga[`KBE_CFGA_IRQ12EN]
                   & cfga[`KBE_CFGA_MSEL]
                   & (route == KBE_ROUTE_INT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // smi/nmi traps
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      xt_trap <= 1'b0;
    end else if (xt_in && xt_sel && kbd_trap_enable_in) begin
      xt_trap <= 1'b1;
    end else if (xt_trap_clear_in) begin
      xt_trap <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      smi_out             <= 1'b0;
      nmi_out             <= 1'b0;
      xt_trap_status_out  <= 1'b0;
      matrix_key_trap_out <= 1'b0;
    end else begin
      smi_out <= (xt_trap | cfgb[`KBE_CFGB_TMR]) & ~trap_nmi_select_in;
      nmi_out <= (xt_trap | cfgb[`KBE_CFGB_TMR]) & trap_nmi_select_in;
      xt_trap_status_out  <= xt_trap;
      matrix_key_trap_out <= matrix_key_event_in & kbd_trap_enable_in
                             & ~xt_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and external route
  always_comb begin
    next_rdata = `KBE_UNMAPPED;
    if (io_addr_in == `KBE_PORT_INDEX) begin
      next_rdata = index;
    end else if (io_addr_in == `KBE_PORT_DATA) begin
      case (index)
        `KBE_IDX_CFGA:  next_rdata = cfga;
        `KBE_IDX_CFGB:  next_rdata = cfgb;
        `KBE_IDX_IBUF:  next_rdata = ibuf;
        `KBE_IDX_KOBUF: next_rdata = obuf;
        `KBE_IDX_MOBUF: next_rdata = obuf;
        `KBE_IDX_STATW: next_rdata = status;
        default:        next_rdata = `KBE_UNMAPPED;
      endcase
    end else if (route == KBE_ROUTE_INT) begin
      if (io_addr_in == `KBE_PORT_OBUF) begin
        next_rdata = obuf;
      end else if (io_addr_in == `KBE_PORT_STAT) begin
        next_rdata = status;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      io_rdata_out       <= `KBE_UNMAPPED;
      ext_kbc_select_out <= 1'b0;
    end else begin
      if (io_rd_in) begin
        io_rdata_out <= next_rdata;
      end
      ext_kbc_select_out <= (wr60 | wr64 | rd60 | rd64)
                            & (route == KBE_ROUTE_EXT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  property p_a20_reset;
    $rose(resetn_in) |-> a20_gate_out;
  endproperty
  a_a20_reset: assert property (p_a20_reset)
    else $error("gate not propagating after reset");

  property p_a20_dis;
    cfga[`KBE_CFGA_A20DIS] |=> !a20_gate_out;
  endproperty
  a_a20_dis: assert property (p_a20_dis)
    else $error("gate still forced while snoop disabled");

  property p_mouse_bit;
    wr_c4 && cfga[`KBE_CFGA_MSEL] && !wr_c5 |=> status[`KBE_STAT_AUX];
  endproperty
  a_mouse_bit: assert property (p_mouse_bit)
    else $error("mouse full bit not set");

  property p_irq12_sel;
    irq12_out |-> $past(cfga[`KBE_CFGA_MSEL]);
  endproperty
  a_irq12_sel: assert property (p_irq12_sel)
    else $error("irq12 without mouse select");

  property p_kbd_irq1;
    wr_c3 && route == KBE_ROUTE_INT && cfga[`KBE_CFGA_IRQ1EN] && !wr_c0
      && !wr_c1 ##1 !rd60 && !wr_c0 && !wr_c1 |=> irq1_out;
  endproperty
  a_kbd_irq1: assert property (p_kbd_irq1)
    else $error("irq1 missing after keyboard buffer write");

  property p_ext_quiet;
    route == KBE_ROUTE_EXT |=> !irq1_out && !irq12_out;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("internal irq with external route");

  property p_timer_w1;
    wr_c1 && io_wdata_in[`KBE_CFGB_TMR] && !cfgb[`KBE_CFGB_TMR]
      && !kbd_timer_timeout_in |=> !cfgb[`KBE_CFGB_TMR];
  endproperty
  a_timer_w1: assert property (p_timer_w1)
    else $error("writing one changed timer status");

  property p_obuf_xt;
    xt_in && !wr_c3 && !wr_c4 |=> obuf == $past(xt_byte);
  endproperty
  a_obuf_xt: assert property (p_obuf_xt)
    else $error("xt byte not in output buffer");

  property p_route_ext;
    (wr60 || rd64) && route == KBE_ROUTE_EXT |=> ext_kbc_select_out;
  endproperty
  a_route_ext: assert property (p_route_ext)
    else $error("external select missing");

  property p_clk_hold;
    xt_en && !cfgb[`KBE_CFGB_CLKREL] |=> xt_clk_oe_out && !xt_clk_out;
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("xt clock not held low");

  c_a20_cmd: cover property (snoop == KBE_SNOOP_DATA ##[1:20] wr60);
  c_xt_byte: cover property (xt_in);
  c_irq1:    cover property ($rose(irq1_out));

endmodule

// ==== bench/kbe_xt_kbd.sv ====
// behavioural serial keyboard driving the open-drain clock and data lines
`timescale 1ns/10ps
module kbe_xt_kbd (
  // pulls from the device
  input  wire logic clk_oe_in,
  input  wire logic data_oe_in,
  // resolved line levels
  output logic      clk_line_out,
  output logic      data_line_out
);
  logic kb_clk;
  logic kb_data;

  // pull-ups win unless a party pulls low
  assign clk_line_out  = kb_clk & ~clk_oe_in;
  assign data_line_out = kb_data & ~data_oe_in;

  initial begin
    kb_clk  = 1'b1;
    kb_data = 1'b1;
  end

  // clock stands high between frames, so no stray edges reach the receiver
  task automatic send(input logic [7:0] b);
    logic [8:0] f;
    int         i;
    f = {b, 1'b1};
    wait (!clk_oe_in && !data_oe_in);
    for (i = 0; i < 9; i++) begin
      kb_data = f[i];
      #160 kb_clk = 1'b0;
      #160 kb_clk = 1'b1;
    end
    kb_data = 1'b1;
  endtask
endmodule

// ==== bench/keyboard_controller_emulation_bench.sv ====
// self-checking bench for the keyboard controller emulation
`timescale 1ns/10ps
module keyboard_controller_emulation_bench;
  logic clock_in, resetn_in, io_wr, io_rd, ext_sel, a20, hot_rst, irq1, irq12;
  logic smi, nmi, xt_trap, mkey_trap, trap_en, nmi_sel, trap_clr, mkey_ev;
  logic tmr_to, xt_clk, xt_data, clk_o, clk_oe, dat_o, dat_oe, ext_seen, seen;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rv, b;
  int          miscompares, n_tests, cycles, seed, r, k;

  kbe_top dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
    .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
    .ext_kbc_select_out(ext_sel), .a20_gate_out(a20),
    .hot_reset_out(hot_rst), .irq1_out(irq1), .irq12_out(irq12),
    .smi_out(smi), .nmi_out(nmi), .xt_trap_status_out(xt_trap),
    .matrix_key_trap_out(mkey_trap), .kbd_trap_enable_in(trap_en),
    .trap_nmi_select_in(nmi_sel), .xt_trap_clear_in(trap_clr),
    .matrix_key_event_in(mkey_ev), .kbd_timer_timeout_in(tmr_to),
    .xt_clk_in(xt_clk), .xt_clk_out(clk_o), .xt_clk_oe_out(clk_oe),
    .xt_data_in(xt_data), .xt_data_out(dat_o), .xt_data_oe_out(dat_oe));

  kbe_xt_kbd kbd_u (.clk_oe_in(clk_oe), .data_oe_in(dat_oe),
    .clk_line_out(xt_clk), .data_line_out(xt_data));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // run length guard: the sequence needs a few hundred cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  function automatic logic [7:0] exp60(input logic [1:0] rt, logic [7:0] d);
    return (rt == 2'b01) ? d : 8'hFF;
  endfunction

  task automatic chk(input logic [7:0] got, logic [7:0] exp, string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t ns: %s", $time, m);
    end
  endtask

  task automatic chk1(input logic got, logic exp, string m);
    chk({7'h00, got}, {7'h00, exp}, m);
  endtask

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle strobes, launched just after an edge and dropped at the next
  task automatic wr(input logic [15:0] a, logic [7:0] d);
    @(posedge clock_in);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clock_in);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clock_in);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clock_in);
    io_rd <= 1'b0;
    #1;
    rv       = io_rdata;
    ext_seen = ext_sel;
  endtask

  task automatic wi(input logic [7:0] i, logic [7:0] d);
    wr(16'h0022, {8'h00, i});
    wr(16'h0023, {8'h00, d});
  endtask

  task automatic ri(input logic [7:0] i);
    wr(16'h0022, {8'h00, i});
    rd(16'h0023);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic pulse(input int s);
    @(posedge clock_in);
    tmr_to   <= (s == 0);
    mkey_ev  <= (s == 1);
    trap_clr <= (s == 2);
    @(posedge clock_in);
    tmr_to   <= 1'b0;
    mkey_ev  <= 1'b0;
    trap_clr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 69270;
    {miscompares, n_tests} = '0;
    {resetn_in, io_wr, io_rd, nmi_sel, trap_clr, mkey_ev, tmr_to} = '0;
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
    trap_en  = 1'b1;
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    tick(1);
    chk1(a20, 1'b1, "gate not propagating after reset");
    ri(8'hC1);
    chk(rv, 8'h00, "cfg b reset value");
    ri(8'hC0);
    chk(rv, 8'h00, "cfg a reset value");
    // every route code, with irq1 enabled
    wi(8'hC0, 8'h10);
    for (r = 0; r < 4; r++) begin
      b = 8'($random(seed));
      wi(8'hC1, {4'h0, r[1:0], 2'b00});
      wi(8'hC3, b);
      tick(2);
      chk1(irq1, r == 1, "irq1 after keyboard buffer write");
      rd(16'h0060);
      chk(rv, exp60(r[1:0], b), "port 60h read data");
      chk1(ext_seen, r == 2, "external select");
      tick(2);
      chk1(irq1, 1'b0, "irq1 kept after 60h read");
    end
    // status bit 5 meanings and mouse irq
    wi(8'hC1, 8'h04);
    wi(8'hC3, b);
    wi(8'hC0, 8'h00);
    tick(2);
    chk1(irq1, 1'b0, "irq1 with enable clear");
    wi(8'hC0, 8'h10);
    tick(2);
    chk1(irq1, 1'b1, "irq1 not raised again by toggle");
    wi(8'hC0, 8'h20);
    wi(8'hC4, b);
    tick(2);
    chk1(irq12, 1'b0, "irq12 in time-out meaning");
    wi(8'hC5, 8'h20);
    rd(16'h0064);
    chk(rv & 8'h20, 8'h20, "status write bit 5");
    wi(8'hC5, 8'h00);
    wi(8'hC4, b);
    rd(16'h0064);
    chk(rv & 8'h20, 8'h00, "bit 5 moved in time-out meaning");
    wi(8'hC0, 8'h21);
    wi(8'hC4, b);
    tick(2);
    chk1(irq12, 1'b1, "irq12 missing in mouse meaning");
    rd(16'h0064);
    chk(rv & 8'h20, 8'h20, "mouse write sets bit 5");
    wi(8'hC3, ~b);
    rd(16'h0064);
    chk(rv & 8'h20, 8'h00, "keyboard write clears bit 5");
    rd(16'h0060);
    chk(rv, ~b, "buffer not holding last write");
    // gate snoop works on a dead route and stops when disabled
    wi(8'hC0, 8'h00);
    wi(8'hC1, 8'h00);
    for (k = 0; k < 3; k++) begin
      if (k == 2) begin
        wi(8'hC0, 8'h02);
      end
      wr(16'h0064, 8'hD1);
      wr(16'h0060, {6'h00, k == 1, 1'b0});
      tick(2);
      chk1(a20, k == 1, "gate level after snoop");
    end
    wr(16'h0064, 8'hFE);
    #1;
    chk1(hot_rst, 1'b1, "hot reset pulse missing");
    wr(16'h0060, b);
    ri(8'hC2);
    chk(rv, b, "cpu write not in input buffer");
    // serial keyboard into the buffer, then to irq1 and to the smi trap
    wi(8'hC0, 8'h10);
    wi(8'hC1, 8'h14);
    tick(2);
    chk1(clk_oe, 1'b1, "clock line not held low");
    chk1(clk_o | dat_o, 1'b0, "pin drive level not low");
    for (k = 0; k < 2; k++) begin
      wi(8'hC1, k ? 8'h35 : 8'h15);
      tick(2);
      chk1(clk_oe, 1'b0, "clock line still held");
      b = 8'($random(seed));
      kbd_u.send(b);
      tick(12);
      chk1(irq1, k == 0, "irq1 from serial byte");
      chk1(xt_trap, k == 1, "serial byte trap status");
      chk1(smi, k == 1, "smi from serial byte");
      rd(16'h0060);
      chk(rv, b, "serial byte in output buffer");
      wi(8'hC1, k ? 8'h37 : 8'h17);
      tick(2);
      chk1(dat_oe, 1'b1, "data line not held by acknowledge");
    end
    pulse(2);
    tick(2);
    chk1(xt_trap, 1'b0, "trap status not cleared");
    // matrix key traps only while bytes go to irq1 and the trap enable is set
    for (k = 0; k < 3; k++) begin
      wi(8'hC1, k ? 8'h15 : 8'h35);
      trap_en <= (k != 2);
      pulse(1);
      #1;
      seen = mkey_trap;
      repeat (2) begin
        tick(1);
        seen = seen | mkey_trap;
      end
      chk1(seen, k == 1, "matrix key trap");
    end
    // keyboard timer status: set by time-out, write 1 ignored, write 0 clears
    nmi_sel <= 1'b1;
    pulse(0);
    tick(2);
    chk1(nmi, 1'b1, "timer nmi missing");
    wi(8'hC1, 8'h55);
    ri(8'hC1);
    chk(rv & 8'h40, 8'h40, "timer status lost on write 1");
    wi(8'hC1, 8'h15);
    ri(8'hC1);
    chk(rv & 8'h40, 8'h00, "timer status kept on write 0");
    chk1(nmi, 1'b0, "timer nmi not cleared");
    stop_test();
  end
endmodule
